// ### verilog/oie_top.sv
// interrupt enables, flags and status of the oscillator controller
// Overview of operation
// - write one bit 8 clears pll lock enable
// - write one bit 4 clears fast osc enable
// - write one bit 1 clears xtal failure enable
// - write one bit 0 clears xtal ready enable
// - request when enable and flag both set
// - set register at 0x04, shared enables, zero reset
// - one status register gathers all oscillator states
`timescale 1ns/1ns
`default_nettype none
`include "oie_defs.svh"
module oie_top (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [`OIE_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic xtal_ready,
    input wire logic xtal_failure,
    input wire logic fast_osc_ready,
    input wire logic pll_locked,
    output logic irq
);
    // reset release chain, async assert, sync release
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // oscillator status levels come from other clock domains
    logic [3:0] raw_status;
    logic [3:0] status_sync;
    assign raw_status = {pll_locked, fast_osc_ready, xtal_failure, xtal_ready};

    oie_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in(raw_status),
        .sync_out(status_sync)
    );

    // status word laid out at the same bit positions as the enables
    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h00000000;
        status_word[`OIE_BIT_XTAL_RDY] = status_sync[oie_pkg::OIE_SRC_XTAL_RDY];
        status_word[`OIE_BIT_XTAL_FAIL] = status_sync[oie_pkg::OIE_SRC_XTAL_FAIL];
        status_word[`OIE_BIT_FAST_RDY] = status_sync[oie_pkg::OIE_SRC_FAST_RDY];
        status_word[`OIE_BIT_PLL_LOCK] = status_sync[oie_pkg::OIE_SRC_PLL_LOCK];
    end

    // previous status for rising edge detection
    logic [31:0] status_prev;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status_prev <= `OIE_FLAGS_RST;
        end else begin
            status_prev <= status_word;
        end
    end

    // any status change (rising) is an event; failure also rising only
    logic [31:0] event_set;
    assign event_set = status_word & ~status_prev & `OIE_SRC_MASK;

    // decoded bus strobes
    logic wr_enclr;
    logic wr_enset;
    logic wr_flags;
    assign wr_enclr = reg_wr && (reg_addr == `OIE_OFF_ENCLR);
    assign wr_enset = reg_wr && (reg_addr == `OIE_OFF_ENSET);
    assign wr_flags = reg_wr && (reg_addr == `OIE_OFF_FLAGS);

    // one shared enable state behind both set and clear views
    logic [31:0] irq_enable;
    logic [31:0] next_irq_enable;
    always_comb begin
        next_irq_enable = irq_enable;
        if (wr_enset) begin
            next_irq_enable = irq_enable | (reg_wdata & `OIE_SRC_MASK);
        end
        if (wr_enclr) begin
            // zeros leave bits alone, ones clear them
            next_irq_enable[`OIE_BIT_PLL_LOCK] = irq_enable[`OIE_BIT_PLL_LOCK]
                & ~reg_wdata[`OIE_BIT_PLL_LOCK];
            next_irq_enable[`OIE_BIT_FAST_RDY] = irq_enable[`OIE_BIT_FAST_RDY]
                & ~reg_wdata[`OIE_BIT_FAST_RDY];
            next_irq_enable[`OIE_BIT_XTAL_FAIL] = irq_enable[`OIE_BIT_XTAL_FAIL]
                & ~reg_wdata[`OIE_BIT_XTAL_FAIL];
            next_irq_enable[`OIE_BIT_XTAL_RDY] = irq_enable[`OIE_BIT_XTAL_RDY]
                & ~reg_wdata[`OIE_BIT_XTAL_RDY];
        end
    end

    // enable register, zero after reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable <= `OIE_ENABLE_RST;
        end else begin
            irq_enable <= next_irq_enable;
        end
    end

    // sticky flags, write one clears, a new event wins over the clear
    logic [31:0] irq_flags;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_flags <= `OIE_FLAGS_RST;
        end else if (wr_flags) begin
            irq_flags <= (irq_flags & ~reg_wdata) | event_set;
        end else begin
            irq_flags <= irq_flags | event_set;
        end
    end

    // registered level request from the next-cycle flags and enables
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_irq_enable & irq_flags & ~(wr_flags ? reg_wdata : 32'h00000000)
                | next_irq_enable & event_set);
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `OIE_OFF_ENCLR: reg_rdata <= irq_enable;
                `OIE_OFF_ENSET: reg_rdata <= irq_enable;
                `OIE_OFF_FLAGS: reg_rdata <= irq_flags;
                `OIE_OFF_STATUS: reg_rdata <= status_word;
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// ### verilog/oie_defs.svh
// register map, field positions and reset values of the oscillator interrupt block
`ifndef OIE_DEFS_SVH
`define OIE_DEFS_SVH
`define OIE_ADDR_W 8
`define OIE_OFF_ENCLR 8'h00
`define OIE_OFF_ENSET 8'h04
`define OIE_OFF_FLAGS 8'h08
`define OIE_OFF_STATUS 8'h0C
`define OIE_BIT_XTAL_RDY 0
`define OIE_BIT_XTAL_FAIL 1
`define OIE_BIT_FAST_RDY 4
`define OIE_BIT_PLL_LOCK 8
`define OIE_ENABLE_RST 32'h00000000
`define OIE_FLAGS_RST 32'h00000000
`define OIE_SRC_MASK 32'h00000113
`endif

// ### verilog/oie_pkg.sv
// types shared by the oscillator interrupt block
package oie_pkg;
    // source index, one entry per oscillator event
    typedef enum logic [1:0] {
        OIE_SRC_XTAL_RDY = 2'h0,
        OIE_SRC_XTAL_FAIL = 2'h1,
        OIE_SRC_FAST_RDY = 2'h2,
        OIE_SRC_PLL_LOCK = 2'h3
    } oie_src_t;
endpackage

// ### verilog/oie_sync.sv
// two flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module oie_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // first stage is read only by the second stage
    logic [WIDTH-1:0] meta;

    // plain double register, reset to low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

// ### verification/oie_top_properties.sv
// port checker of the oscillator interrupt block
`timescale 1ns/1ns
`default_nettype none
module oie_chk (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // read data stand only in the cycle after a read
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("stray data");
    // both views share one enable state
    set_view_a: assert property (reg_wr && reg_addr == 8'h04 ##1 !reg_wr ##1 reg_rd &&
        reg_addr == 8'h00 |=> (reg_rdata & $past(reg_wdata, 3) & 32'h113) ==
        ($past(reg_wdata, 3) & 32'h113)) else $error("set lost");
    clr_view_a: assert property (reg_wr && reg_addr == 8'h00 ##1 !reg_wr ##1 reg_rd &&
        reg_addr == 8'h04 |=> (reg_rdata & $past(reg_wdata, 3)) == 32'h0) else $error("clr lost");
    same_view_a: assert property (reg_rd && reg_addr == 8'h00 ##1 !reg_wr ##1 reg_rd &&
        reg_addr == 8'h04 |=> reg_rdata == $past(reg_rdata, 2)) else $error("views differ");
    // refused places and spare bits read zero
    unmapped_rd_a: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata == 32'h0)
        else $error("unmapped data");
    spare_bits_a: assert property (reg_rd && reg_addr[7:3] == 5'h00 |=>
        (reg_rdata & ~32'h113) == 32'h0) else $error("spare bits");
    // request gone once every enable is cleared; it only drops on a write
    all_off_a: assert property (reg_wr && reg_addr == 8'h00 &&
        (reg_wdata & 32'h113) == 32'h113 |-> ##2 !irq) else $error("irq stays");
    irq_fall_a: assert property ($fell(irq) |-> $past(reg_wr))
        else $error("irq fell alone");
endmodule
bind oie_top oie_chk u_chk (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq);
`default_nettype wire

// ### verification/tb_oscillator_irq_enables.sv
// self-checking bench of the oscillator interrupt block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED at %0t: %h vs %h", $time, (a), (b)); end end
module tb_oscillator_irq_enables;
    logic clk_sys = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, irq;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d, exp;
    logic [3:0] src = 4'h0; // status levels: xtal ready, failure, fast ready, pll lock
    logic [31:0] bits [4] = '{32'h1, 32'h2, 32'h10, 32'h100}; // enable bit per source
    int mismatches = 0;
    int total_checks = 0;
    oie_top dut (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
        .xtal_ready(src[0]), .xtal_failure(src[1]), .fast_osc_ready(src[2]), .pll_locked(src[3]));
    // 125 MHz system clock
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    // one access, then an idle cycle so a strobe never toggles twice in a step
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        {reg_wr, reg_rd} <= {w, !w};
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        {reg_wr, reg_rd} <= 2'h0;
        #1 d = reg_rdata;
        @(posedge clk_sys);
    endtask
    // look at the request mid-cycle, return just after an edge
    task automatic chk_irq(input logic e);
        @(negedge clk_sys);
        `CHK(irq, e)
        @(posedge clk_sys);
    endtask
    // set all, then drop one source at a time through the clear view
    task automatic t_set_clear;
        bus(1'h0, 8'h04, 32'h0);
        `CHK(d, 32'h0)
        bus(1'h1, 8'h04, 32'hFFFFFFFF);
        bus(1'h0, 8'h00, 32'h0);
        `CHK(d, 32'h113)
        bus(1'h0, 8'h04, 32'h0);
        `CHK(d, 32'h113)
        bus(1'h0, 8'h10, 32'h0);
        `CHK(d, 32'h0)
        exp = 32'h113;
        for (int i = 0; i < 4; i++) begin
            bus(1'h1, 8'h00, bits[i]);
            exp = exp & ~bits[i];
            bus(1'h0, 8'h04, 32'h0);
            `CHK(d, exp)
        end
    endtask
    // each source requests only while enabled and flagged; the flag is sticky
    task automatic t_irq;
        for (int i = 0; i < 4; i++) begin
            bus(1'h1, 8'h04, bits[i]);
            src[i] <= 1'h1;
            repeat (4) @(posedge clk_sys);
            chk_irq(1'h1);
            bus(1'h0, 8'h08, 32'h0);
            `CHK(d, bits[i])
            bus(1'h0, 8'h0C, 32'h0);
            `CHK(d, bits[i])
            bus(1'h1, 8'h00, bits[i]);
            chk_irq(1'h0);
            bus(1'h1, 8'h04, bits[i]);
            chk_irq(1'h1);
            src[i] <= 1'h0;
            bus(1'h1, 8'h08, bits[i]);
            chk_irq(1'h0);
            bus(1'h0, 8'h0C, 32'h0);
            `CHK(d, 32'h0)
        end
        bus(1'h1, 8'h00, 32'hFFFFFFFF);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // reset for six cycles, then the scenarios
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'h1;
        repeat (3) @(posedge clk_sys);
        t_set_clear();
        t_irq();
        final_report();
    end
    // hang guard, well beyond the roughly 125 cycles needed
    initial begin
        #20000;
        mismatches++;
        final_report();
    end
endmodule
`default_nettype wire
